// ---- tamper_checker.sv ----
// protection descriptor tamper checker core
`timescale 1ns/1ps
`default_nettype none
module tamper_checker
  import tamper_checker_pkg::*;
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  // register port
  input  wire logic [3:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  output logic                       o_irq,
  // table descriptor bytes
  input  wire logic                  i_pmt_start,
  input  wire logic                  i_pmt_valid,
  input  wire logic                  i_pmt_first,
  input  wire logic                  i_pmt_loop2,
  input  wire logic [7:0]            i_pmt_byte,
  // control message entries
  input  wire logic                  i_ecm_start,
  input  wire logic                  i_ent_valid,
  input  wire logic [7:0]            i_ent_tag,
  input  wire logic [7:0]            i_ent_level,
  input  wire logic [31:0]           i_ent_code,
  input  wire logic                  i_ecm_end,
  input  wire logic                  i_ecm_has_desc,
  input  wire logic [`TC_SLOT_W-1:0] i_ecm_slot,
  input  wire logic [7:0]            i_ecm_thresh,
  // per-service tamper state
  output logic [`TC_NSLOT-1:0]       o_tamper
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [`TC_NSLOT-1:0] status;  // sticky tamper events
    logic [`TC_NSLOT-1:0] mask;    // interrupt mask
    logic                 en;      // checking enabled
    logic [7:0]           rdata;   // read answer
    pmt_st_e              pst;     // descriptor walker
    logic [7:0]           idx;     // body byte index
    logic [7:0]           len;     // descriptor length
    logic [7:0]           tag;     // current tag
    logic                 loop2;   // current descriptor in loop2
    logic [7:0]           fld;     // first body byte
    logic                 done;    // descriptor just ended
    logic                 cc_l1;   // copy control seen in loop1
    logic                 cc_l2;   // copy control seen in loop2
    logic                 ca_any;  // availability seen anywhere
    logic [31:0]          cc_crc;  // crc of loop1 copy control
    logic [31:0]          ca_crc;  // crc of availability
    logic [7:0]           cc_fld;  // copy control field byte
    logic [7:0]           ca_fld;  // availability field byte
    logic                 bad;     // mismatch in this message
    logic                 last_bad;// result of last message
    logic [`TC_NSLOT-1:0] tamper;  // tamper state per service
  } core_s;

  core_s    st_q;
  core_s    st_d;
  logic [31:0] crc_val;   // crc of the descriptor just ended
  logic        crc_en;    // feed byte to crc
  logic        crc_init;  // byte is a tag
  logic        cnt_clr_all;
  logic        cnt_clr;
  logic        cnt_inc;
  cnt_arr_t    cnt;       // counter values
  logic        ent_bad;   // current entry mismatches
  logic        bad_now;   // message result incl. this cycle
  logic        chk_on;    // message takes part in checking
  logic [7:0]  cnt_next;  // counter after this increment

  // ****************************************
  // entry evaluation
  // ****************************************
  // compare one reference entry with the table snapshot
  always_comb begin
    ent_bad = 1'b0;
    case (i_ent_tag)
      `TC_TAG_COPY: begin
        if (i_ent_level == `TC_LVL_CRC ||
            i_ent_level == `TC_LVL_FIELD) begin
          ent_bad = !st_q.cc_l1 || st_q.cc_l2;
          if (i_ent_level == `TC_LVL_CRC) begin
            ent_bad = ent_bad || (st_q.cc_crc != i_ent_code);
          end else begin
            ent_bad = ent_bad ||
              (i_ent_code[31:24] & `TC_RC_CC_MASK) !=
              {st_q.cc_fld[`TC_CC_REC], st_q.cc_fld[`TC_CC_KIND],
               st_q.cc_fld[`TC_CC_APS], 2'b00};
          end
        end
      end
      `TC_TAG_AVAIL: begin
        if (i_ent_level == `TC_LVL_CRC ||
            i_ent_level == `TC_LVL_FIELD) begin
          ent_bad = !st_q.ca_any;
          if (i_ent_level == `TC_LVL_CRC) begin
            ent_bad = ent_bad || (st_q.ca_crc != i_ent_code);
          end else begin
            ent_bad = ent_bad ||
              (i_ent_code[31:24] & `TC_RC_CA_MASK) !=
              {st_q.ca_fld[`TC_CA_KEEP], st_q.ca_fld[`TC_CA_DUR],
               st_q.ca_fld[`TC_CA_CIPH], 3'b000};
          end
        end
      end
      default: ent_bad = 1'b0;
    endcase
  end

  // ****************************************
  // message verdict
  // ****************************************
  // all entries fold into one verdict
  assign bad_now  = st_q.bad || (i_ent_valid && ent_bad);
  assign chk_on   = i_ecm_has_desc && i_ecm_thresh != `TC_THR_OFF;
  // counter commands at message end
  always_comb begin
    cnt_clr_all = 1'b0;
    cnt_clr     = 1'b0;
    cnt_inc     = 1'b0;
    if (i_ecm_end && st_q.en) begin
      if (!chk_on) begin
        cnt_clr_all = 1'b1;
      end else if (bad_now) begin
        cnt_inc = 1'b1;
      end else begin
        cnt_clr = 1'b1;
      end
    end
  end
  // saturating next count for the tamper decision
  assign cnt_next = (cnt[i_ecm_slot] == `TC_CNT_MAX) ? `TC_CNT_MAX :
                    cnt[i_ecm_slot] + 8'h01;

  // ****************************************
  // crc feed
  // ****************************************
  // every descriptor byte goes through the crc
  assign crc_init = st_q.pst == PS_IDLE;
  assign crc_en   = i_pmt_valid && (st_q.pst != PS_IDLE || i_pmt_first);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    // descriptor walker
    if (i_pmt_valid) begin
      case (st_q.pst)
        PS_IDLE: begin
          if (i_pmt_first) begin
            st_d.tag   = i_pmt_byte;
            st_d.loop2 = i_pmt_loop2;
            st_d.pst   = PS_LEN;
          end
        end
        PS_LEN: begin
          st_d.len = i_pmt_byte;
          st_d.idx = 8'h00;
          st_d.fld = 8'h00;
          if (i_pmt_byte == 8'h00) begin
            st_d.done = 1'b1;
            st_d.pst  = PS_IDLE;
          end else begin
            st_d.pst = PS_BODY;
          end
        end
        PS_BODY: begin
          if (st_q.idx == 8'h00) st_d.fld = i_pmt_byte;
          st_d.idx = st_q.idx + 8'h01;
          if (st_q.idx + 8'h01 == st_q.len) begin
            st_d.done = 1'b1;
            st_d.pst  = PS_IDLE;
          end
        end
        default: st_d.pst = PS_IDLE;
      endcase
    end
    // record a finished descriptor into the snapshot
    if (st_q.done) begin
      if (st_q.tag == `TC_TAG_COPY) begin
        if (st_q.loop2) begin
          st_d.cc_l2 = 1'b1;
        end else if (!st_q.cc_l1) begin
          st_d.cc_l1  = 1'b1;
          st_d.cc_crc = crc_val;
          st_d.cc_fld = st_q.fld;
        end
      end else if (st_q.tag == `TC_TAG_AVAIL && !st_q.ca_any) begin
        st_d.ca_any = 1'b1;
        st_d.ca_crc = crc_val;
        st_d.ca_fld = st_q.fld;
      end
    end
    // new table restarts the snapshot
    if (i_pmt_start) begin
      st_d.pst    = PS_IDLE;
      st_d.cc_l1  = 1'b0;
      st_d.cc_l2  = 1'b0;
      st_d.ca_any = 1'b0;
    end
    // message accumulation
    if (i_ecm_start) st_d.bad = 1'b0;
    else if (i_ent_valid && ent_bad) st_d.bad = 1'b1;
    // message end: verdict, tamper state
    if (i_ecm_end && st_q.en) begin
      st_d.bad      = 1'b0;
      st_d.last_bad = chk_on && bad_now;
      if (cnt_clr_all) begin
        st_d.tamper = '0;
      end else if (cnt_clr) begin
        st_d.tamper[i_ecm_slot] = 1'b0;
      end else if (cnt_next > i_ecm_thresh &&
                   !st_q.tamper[i_ecm_slot]) begin
        st_d.tamper[i_ecm_slot] = 1'b1;
      end
    end
    // register writes; status clear is write one
    if (i_wr) begin
      case (i_addr)
        `TC_REG_STATUS: st_d.status = st_d.status & ~i_wdata[3:0];
        `TC_REG_MASK:   st_d.mask   = i_wdata[3:0];
        `TC_REG_CTRL:   st_d.en     = i_wdata[0];
        default:        st_d.en     = st_d.en;
      endcase
    end
    // new tamper events set status; set wins over clear
    st_d.status = st_d.status | (st_d.tamper & ~st_q.tamper);
    // read answer for the next cycle
    st_d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `TC_REG_STATUS: st_d.rdata = {4'h0, st_q.status};
        `TC_REG_MASK:   st_d.rdata = {4'h0, st_q.mask};
        `TC_REG_CTRL:   st_d.rdata = {7'h00, st_q.en};
        `TC_REG_TAMPER: st_d.rdata = {4'h0, st_q.tamper};
        `TC_REG_SNAP:   st_d.rdata = {4'h0, st_q.last_bad, st_q.ca_any,
                                      st_q.cc_l2, st_q.cc_l1};
        default: begin
          if (i_addr[3] && i_addr[2:0] < 3'(`TC_NSLOT))
            st_d.rdata = cnt[i_addr[`TC_SLOT_W-1:0]];
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q      <= '0;
      st_q.pst  <= PS_IDLE;
      st_q.en   <= `TC_CTRL_RST;
      st_q.mask <= `TC_MASK_RST;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // sub-blocks
  // ****************************************
  // crc over each table descriptor
  tamper_crc32 u_crc (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_init    (crc_init),
    .i_en      (crc_en),
    .i_byte    (i_pmt_byte),
    .o_crc     (crc_val)
  );
  tamper_cnt_bank u_cnt (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_clr_all (cnt_clr_all),
    .i_clr     (cnt_clr),
    .i_inc     (cnt_inc),
    .i_slot    (i_ecm_slot),
    .o_cnt     (cnt)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata  = st_q.rdata;
  assign o_tamper = st_q.tamper;
  assign o_irq    = |(st_q.status & st_q.mask);
endmodule
`default_nettype wire

// ---- tamper_checker_assertions.sv ----
// port-level assertions for the tamper checker
`timescale 1ns/1ps
`default_nettype none
`include "tamper_checker_consts.svh"
module tamper_checker_sva (
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst_n,
  input wire logic                  i_ce,
  input wire logic [3:0]            i_addr,
  input wire logic [7:0]            i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [7:0]            o_rdata,
  input wire logic                  o_irq,
  input wire logic                  i_ecm_end,
  input wire logic                  i_ecm_has_desc,
  input wire logic [`TC_SLOT_W-1:0] i_ecm_slot,
  input wire logic [7:0]            i_ecm_thresh,
  input wire logic [`TC_NSLOT-1:0]  o_tamper
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // helper state
  // ****************************************
  logic                 en_q;   // shadow of the enable bit
  logic [`TC_NSLOT-1:0] keep_q; // slots untouched by the last message
  // track enable writes and the slot of each cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q   <= `TC_CTRL_RST;
      keep_q <= '1;
    end else begin
      if (i_ce && i_wr && i_addr == `TC_REG_CTRL) begin
        en_q <= i_wdata[0];
      end
      keep_q             <= '1;
      keep_q[i_ecm_slot] <= 1'b0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_rdata_idle;
    $past(i_ce) && !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  property p_rd_unmapped;
    i_ce && i_rd && (i_addr inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF})
      |=> o_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read returned data");
  property p_rd_tamper;
    i_ce && i_rd && i_addr == `TC_REG_TAMPER
      |=> o_rdata == {4'h0, $past(o_tamper)};
  endproperty
  a_rd_tamper: assert property (p_rd_tamper)
    else $error("tamper register read differs from tamper port");
  property p_tamper_hold;
    !(i_ce && i_ecm_end && en_q) |=> $stable(o_tamper);
  endproperty
  a_tamper_hold: assert property (p_tamper_hold)
    else $error("tamper state moved without message end");
  property p_nodesc_clear;
    i_ce && i_ecm_end && en_q && !i_ecm_has_desc |=> o_tamper == '0;
  endproperty
  a_nodesc_clear: assert property (p_nodesc_clear)
    else $error("message without descriptor left tamper set");
  property p_thr_zero;
    i_ce && i_ecm_end && en_q && i_ecm_thresh == `TC_THR_OFF |=> o_tamper == '0;
  endproperty
  a_thr_zero: assert property (p_thr_zero)
    else $error("zero threshold left tamper set");
  property p_other_slots;
    i_ce && i_ecm_end && en_q && i_ecm_has_desc && i_ecm_thresh != 8'h00
      |=> ((o_tamper ^ $past(o_tamper)) & keep_q) == '0;
  endproperty
  a_other_slots: assert property (p_other_slots)
    else $error("message touched another service");
  property p_rise_cause;
    (o_tamper & ~$past(o_tamper)) != '0 |-> $past(i_ecm_end)
      && $past(i_ecm_has_desc) && $past(i_ecm_thresh) != 8'h00;
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("tamper raised without checked message");
  property p_irq_mask_off;
    i_ce && i_wr && i_addr == `TC_REG_MASK && i_wdata[3:0] == 4'h0 |=> !o_irq;
  endproperty
  a_irq_mask_off: assert property (p_irq_mask_off)
    else $error("interrupt high with mask cleared");
endmodule
bind tamper_checker tamper_checker_sva tamper_checker_sva_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .i_ecm_end(i_ecm_end), .i_ecm_has_desc(i_ecm_has_desc),
  .i_ecm_slot(i_ecm_slot), .i_ecm_thresh(i_ecm_thresh), .o_tamper(o_tamper)
);
`default_nettype wire

// ---- tamper_checker_consts.svh ----
// named constants for the protection descriptor tamper checker
`ifndef TAMPER_CHECKER_CONSTS_SVH
`define TAMPER_CHECKER_CONSTS_SVH
// ****************************************
// sizes
// ****************************************
`define TC_NSLOT        4
`define TC_SLOT_W       2
`define TC_CNT_MAX      8'hFF
`define TC_THR_OFF      8'h00
// ****************************************
// register offsets and reset values
// ****************************************
`define TC_REG_STATUS   4'h0
`define TC_REG_MASK     4'h1
`define TC_REG_CTRL     4'h2
`define TC_REG_TAMPER   4'h3
`define TC_REG_SNAP     4'h4
`define TC_REG_CNT0     4'h8
`define TC_CTRL_RST     1'h1
`define TC_MASK_RST     4'h0
// ****************************************
// descriptor tags and check levels
// ****************************************
`define TC_TAG_COPY     8'hC1
`define TC_TAG_AVAIL    8'hDE
`define TC_LVL_CRC      8'h00
`define TC_LVL_FIELD    8'h01
// ****************************************
// field layouts
// ****************************************
`define TC_CC_REC       7:6
`define TC_CC_KIND      3:2
`define TC_CC_APS       1:0
`define TC_CA_KEEP      4
`define TC_CA_DUR       3:1
`define TC_CA_CIPH      0
`define TC_RC_CC_MASK   8'hFC
`define TC_RC_CA_MASK   8'hF8
// ****************************************
// section crc
// ****************************************
`define TC_CRC_POLY     32'h04C11DB7
`define TC_CRC_INIT     32'hFFFFFFFF
`endif

// ---- tamper_checker_pkg.sv ----
// types shared by the tamper checker modules
`include "tamper_checker_consts.svh"
package tamper_checker_pkg;
  // ****************************************
  // descriptor walker states
  // ****************************************
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_LEN,
    PS_BODY
  } pmt_st_e;
  // ****************************************
  // counter bank contents
  // ****************************************
  typedef logic [`TC_NSLOT-1:0][7:0] cnt_arr_t;
  // ****************************************
  // crc engine state
  // ****************************************
  typedef struct packed {
    logic [31:0] crc;
  } crc_s;
  // ****************************************
  // counter bank state
  // ****************************************
  typedef struct packed {
    cnt_arr_t cnt;
  } cnt_s;
endpackage

// ---- tamper_cnt_bank.sv ----
// per-service mismatch counters
`timescale 1ns/1ps
`default_nettype none
module tamper_cnt_bank
  import tamper_checker_pkg::*;
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire logic                  i_clr_all,
  input  wire logic                  i_clr,
  input  wire logic                  i_inc,
  input  wire logic [`TC_SLOT_W-1:0] i_slot,
  output cnt_arr_t                   o_cnt
);
  cnt_s st_q;
  cnt_s st_d;
  // clear all wins, then one slot clears or steps with saturation
  always_comb begin
    st_d = st_q;
    if (i_clr_all) begin
      st_d.cnt = '0;
    end else if (i_clr) begin
      st_d.cnt[i_slot] = 8'h00;
    end else if (i_inc && st_q.cnt[i_slot] != `TC_CNT_MAX) begin
      st_d.cnt[i_slot] = st_q.cnt[i_slot] + 8'h01;
    end
  end
  // state register, frozen by the clock enable
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) st_q <= '0;
    else if (i_ce) st_q <= st_d;
  end
  assign o_cnt = st_q.cnt;
endmodule
`default_nettype wire

// ---- tamper_crc32.sv ----
// byte-serial crc engine over one descriptor
`timescale 1ns/1ps
`default_nettype none
module tamper_crc32
  import tamper_checker_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_init,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_byte,
  output logic      [31:0] o_crc
);
  // one byte through the msb-first section crc
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ b[i]) ? ((r << 1) ^ `TC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
  crc_s st_q;
  crc_s st_d;
  // next value: init restarts at the seed, then takes the byte
  always_comb begin
    st_d = st_q;
    if (i_en) begin
      st_d.crc = crc_step(i_init ? `TC_CRC_INIT : st_q.crc, i_byte);
    end
  end
  // state register, frozen by the clock enable
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) st_q <= '{crc: `TC_CRC_INIT};
    else if (i_ce) st_q <= st_d;
  end
  assign o_crc = st_q.crc;
endmodule
`default_nettype wire

// ---- tamper_parser_model.sv ----
// behavioural section parser feeding table bytes and control messages
`timescale 1ns/1ps
`default_nettype none
`include "tamper_checker_consts.svh"
module tamper_parser_model (
  input  wire logic                  i_clk_sys,
  output logic                       o_pmt_start,
  output logic                       o_pmt_valid,
  output logic                       o_pmt_first,
  output logic                       o_pmt_loop2,
  output logic [7:0]                 o_pmt_byte,
  output logic                       o_ecm_start,
  output logic                       o_ent_valid,
  output logic [7:0]                 o_ent_tag,
  output logic [7:0]                 o_ent_level,
  output logic [31:0]                o_ent_code,
  output logic                       o_ecm_end,
  output logic                       o_ecm_has_desc,
  output logic [`TC_SLOT_W-1:0]      o_ecm_slot,
  output logic [7:0]                 o_ecm_thresh
);
  // idle values at time zero
  initial begin
    {o_pmt_start, o_pmt_valid, o_pmt_first, o_pmt_loop2, o_pmt_byte} = '0;
    {o_ecm_start, o_ent_valid, o_ent_tag, o_ent_level, o_ent_code} = '0;
    {o_ecm_end, o_ecm_has_desc, o_ecm_slot, o_ecm_thresh} = '0;
  end
  // new table: snapshot restarts
  task automatic tbl_start();
    @(posedge i_clk_sys);
    o_pmt_start <= 1'b1;
    @(posedge i_clk_sys);
    o_pmt_start <= 1'b0;
  endtask
  // one descriptor of length one, then the settle gap
  task automatic desc(input logic [7:0] tag, input logic l2,
                      input logic [7:0] b);
    @(posedge i_clk_sys);
    o_pmt_valid <= 1'b1;
    o_pmt_first <= 1'b1;
    o_pmt_loop2 <= l2;
    o_pmt_byte  <= tag;
    @(posedge i_clk_sys);
    o_pmt_first <= 1'b0;
    o_pmt_byte  <= 8'h01;
    @(posedge i_clk_sys);
    o_pmt_byte  <= b;
    @(posedge i_clk_sys);
    o_pmt_valid <= 1'b0;
    o_pmt_byte  <= ~b;
    o_pmt_loop2 <= ~l2;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // control message start pulse
  task automatic ecm_go();
    @(posedge i_clk_sys);
    o_ecm_start <= 1'b1;
    @(posedge i_clk_sys);
    o_ecm_start <= 1'b0;
  endtask
  // one reference entry; code lines flip once released
  task automatic ent(input logic [7:0] tag, input logic [7:0] lvl,
                     input logic [31:0] code);
    @(posedge i_clk_sys);
    o_ent_valid <= 1'b1;
    o_ent_tag   <= tag;
    o_ent_level <= lvl;
    o_ent_code  <= code;
    @(posedge i_clk_sys);
    o_ent_valid <= 1'b0;
    o_ent_code  <= ~code;
  endtask
  // message end with its qualifiers
  task automatic ecm_done(input logic has, input logic [1:0] slot,
                          input logic [7:0] thr);
    @(posedge i_clk_sys);
    o_ecm_end      <= 1'b1;
    o_ecm_has_desc <= has;
    o_ecm_slot     <= slot;
    o_ecm_thresh   <= thr;
    @(posedge i_clk_sys);
    o_ecm_end      <= 1'b0;
    o_ecm_has_desc <= ~has;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the tamper checker
`timescale 1ns/1ps
`default_nettype none
`include "tamper_checker_consts.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  rdata, ent_tag, ent_level, ecm_thresh, pmt_byte;
  logic        irq, pmt_start, pmt_valid, pmt_first, pmt_loop2;
  logic        ecm_start, ent_valid, ecm_end, ecm_has_desc;
  logic [31:0] ent_code;
  logic [1:0]  ecm_slot;
  logic [3:0]  tamper;
  logic [7:0]  cm [3] = '{8'h58, 8'hF8, 8'hD0}; // one field flipped each
  int          n_errors = 0;
  int          n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  tamper_checker tamper_checker_inst (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .i_pmt_start(pmt_start), .i_pmt_valid(pmt_valid),
    .i_pmt_first(pmt_first), .i_pmt_loop2(pmt_loop2),
    .i_pmt_byte(pmt_byte), .i_ecm_start(ecm_start),
    .i_ent_valid(ent_valid), .i_ent_tag(ent_tag), .i_ent_level(ent_level),
    .i_ent_code(ent_code), .i_ecm_end(ecm_end),
    .i_ecm_has_desc(ecm_has_desc), .i_ecm_slot(ecm_slot),
    .i_ecm_thresh(ecm_thresh), .o_tamper(tamper));
  tamper_parser_model tamper_parser_model_inst (
    .i_clk_sys(clk_sys), .o_pmt_start(pmt_start), .o_pmt_valid(pmt_valid),
    .o_pmt_first(pmt_first), .o_pmt_loop2(pmt_loop2),
    .o_pmt_byte(pmt_byte), .o_ecm_start(ecm_start),
    .o_ent_valid(ent_valid), .o_ent_tag(ent_tag), .o_ent_level(ent_level),
    .o_ent_code(ent_code), .o_ecm_end(ecm_end),
    .o_ecm_has_desc(ecm_has_desc), .o_ecm_slot(ecm_slot),
    .o_ecm_thresh(ecm_thresh));
  // section crc over tag, length and one body byte, msb first
  function automatic logic [31:0] crc3(input logic [23:0] d);
    logic [31:0] c;
    c = `TC_CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `TC_CRC_POLY : 32'h0);
    end
    return c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // one message holding a single entry
  task automatic msg1(input logic [7:0] tg, input logic [7:0] lv,
                      input logic [31:0] cd, input logic has,
                      input logic [1:0] s, input logic [7:0] thr);
    tamper_parser_model_inst.ecm_go();
    tamper_parser_model_inst.ent(tg, lv, cd);
    tamper_parser_model_inst.ecm_done(has, s, thr);
  endtask
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`TC_REG_CTRL, 8'h01);
    rd_chk(`TC_REG_STATUS, 8'h00);
    rd_chk(4'hF, 8'h00);
    $display("test reset values done");
    tamper_parser_model_inst.tbl_start();
    tamper_parser_model_inst.desc(`TC_TAG_COPY, 1'b0, 8'hC6);
    tamper_parser_model_inst.desc(`TC_TAG_AVAIL, 1'b0, 8'h1B);
    tamper_parser_model_inst.desc(8'h48, 1'b0, 8'h33);
    tamper_parser_model_inst.ecm_go();
    tamper_parser_model_inst.ent(`TC_TAG_COPY, 8'h01, 32'hDBFFFFFF);
    tamper_parser_model_inst.ent(`TC_TAG_AVAIL, 8'h01, 32'hDF000000);
    tamper_parser_model_inst.ent(`TC_TAG_COPY, 8'h00, crc3(24'hC101C6));
    tamper_parser_model_inst.ent(`TC_TAG_AVAIL, 8'h00, crc3(24'hDE011B));
    tamper_parser_model_inst.ent(`TC_TAG_COPY, 8'h02, 32'h0);
    tamper_parser_model_inst.ent(8'h55, 8'h00, 32'h0);
    tamper_parser_model_inst.ecm_done(1'b1, 2'd0, 8'd1);
    rd_chk(`TC_REG_CNT0, 8'h00);
    rd_chk(`TC_REG_SNAP, 8'h05);
    $display("test clean message done");
    for (int i = 0; i < 7; i++) begin
      tamper_parser_model_inst.ecm_go();
      tamper_parser_model_inst.ent((i < 3) ? `TC_TAG_COPY : `TC_TAG_AVAIL,
        (i < 6) ? 8'h01 : 8'h00, (i < 6) ? {cm[i % 3], 24'h0}
        : crc3(24'hDE011B) ^ 32'h1);
      if (i == 0) begin
        tamper_parser_model_inst.ent(`TC_TAG_COPY, 8'h00, 32'h0);
      end
      tamper_parser_model_inst.ecm_done(1'b1, 2'd1, 8'd6);
      rd_chk(4'h9, 8'(i + 1));
      chk({7'h0, tamper[1]}, (i == 6) ? 8'h01 : 8'h00);
    end
    rd_chk(`TC_REG_STATUS, 8'h02);
    chk({7'h0, irq}, 8'h00);
    reg_wr(`TC_REG_MASK, 8'h02);
    @(posedge clk_sys);
    #1 chk({7'h0, irq}, 8'h01);
    reg_wr(`TC_REG_STATUS, 8'h02);
    @(posedge clk_sys);
    #1 chk({7'h0, irq}, 8'h00);
    msg1(`TC_TAG_COPY, 8'h01, 32'hD8000000, 1'b1, 2'd1, 8'd6);
    rd_chk(4'h9, 8'h00);
    rd_chk(`TC_REG_TAMPER, 8'h00);
    $display("test mismatch run done");
    repeat (2) msg1(`TC_TAG_COPY, 8'h01, 32'h0, 1'b1, 2'd2, 8'd1);
    rd_chk(`TC_REG_TAMPER, 8'h04);
    msg1(`TC_TAG_COPY, 8'h01, 32'h0, 1'b1, 2'd2, 8'd0);
    rd_chk(4'hA, 8'h00);
    rd_chk(`TC_REG_TAMPER, 8'h00);
    msg1(`TC_TAG_COPY, 8'h01, 32'h0, 1'b1, 2'd3, 8'd1);
    rd_chk(4'hB, 8'h01);
    msg1(`TC_TAG_COPY, 8'h01, 32'h0, 1'b0, 2'd3, 8'd1);
    rd_chk(4'hB, 8'h00);
    $display("test threshold zero and absent done");
    tamper_parser_model_inst.tbl_start();
    tamper_parser_model_inst.desc(`TC_TAG_COPY, 1'b0, 8'hC6);
    tamper_parser_model_inst.desc(`TC_TAG_COPY, 1'b1, 8'hC6);
    msg1(`TC_TAG_COPY, 8'h01, 32'hD8000000, 1'b1, 2'd0, 8'd255);
    rd_chk(`TC_REG_CNT0, 8'h01);
    msg1(`TC_TAG_AVAIL, 8'h01, 32'hD8000000, 1'b1, 2'd0, 8'd255);
    rd_chk(`TC_REG_CNT0, 8'h02);
    tamper_parser_model_inst.tbl_start();
    msg1(`TC_TAG_COPY, 8'h00, crc3(24'hC101C6), 1'b1, 2'd0, 8'd255);
    rd_chk(`TC_REG_CNT0, 8'h03);
    $display("test presence done");
    reg_wr(`TC_REG_CTRL, 8'h00);
    msg1(`TC_TAG_COPY, 8'h01, 32'h0, 1'b1, 2'd0, 8'd1);
    rd_chk(`TC_REG_CNT0, 8'h03);
    reg_wr(`TC_REG_CTRL, 8'h01);
    rd_chk(`TC_REG_CTRL, 8'h01);
    $display("test disable done");
    end_of_test();
  end
endmodule
`default_nettype wire
